// ==== rsf_pkg.sv ====
// Shared constants for the rotate/set file-op decoder.
// Assumes a 100 MHz core clock; one instruction cycle is four clock phases.
// Overview of operation
// - Opcode 0011_00 with d, a and 8-bit f decodes rotate via carry.
// - Via-carry rotate shifts right; bit 0 to carry, carry to bit 7.
// - Via-carry rotate updates carry, negative and zero; rest kept.
// - Rotate destination 0 writes working register, 1 the file register.
// - Opcode 0100_00 decodes plain rotate; bit 0 goes to bit 7.
// - Plain rotate updates only negative and zero, carry untouched.
// - Opcode 0110_100 plus a writes ff to file; no flags, no W target.
// - Bank bit 0 selects access bank; 1 uses bank select register.
// - Bank bit 0 with extended set and f at most 5f uses indexed offset.
// - One word, one cycle: decode, read, process, write in Q1 to Q4.
// - File address is 8 bits spanning 0 to 255; d and a are single bits.
// - Instruction cycle is always four oscillator periods.
// - Logic is fully static; state holds while the clock stands still.
package rsf_pkg;
   // Opcode fields
   localparam logic [5:0] RSF_OP_RRC     = 6'h0c; // 0011_00
   localparam logic [5:0] RSF_OP_RRN     = 6'h10; // 0100_00
   localparam logic [6:0] RSF_OP_SET     = 7'h34; // 0110_100
   localparam int         RSF_D_BIT      = 9;
   localparam int         RSF_A_BIT      = 8;
   // Addressing
   localparam logic [7:0] RSF_IDX_LIMIT  = 8'h5f;
   localparam logic [7:0] RSF_ACC_SPLIT  = 8'h60;
   localparam logic [3:0] RSF_ACC_LO_BNK = 4'h0;
   localparam logic [3:0] RSF_ACC_HI_BNK = 4'hf;
   localparam logic [7:0] RSF_ALL_ONES   = 8'hff;
   // Status flag positions
   localparam int         RSF_C_BIT      = 0;
   localparam int         RSF_Z_BIT      = 2;
   localparam int         RSF_N_BIT      = 4;
   // Timing
   localparam int         RSF_CLK_NS     = 10;
   localparam int         RSF_PHASES     = 4;
   localparam logic [7:0] RSF_STATUS_RST = 8'h00;
   localparam logic [7:0] RSF_W_RST      = 8'h00;
   // Operation kinds
   typedef enum logic [1:0] {
      RSF_NONE = 2'b00,
      RSF_RRC  = 2'b01,
      RSF_RRN  = 2'b10,
      RSF_SET_FILE_ALL_ONES = 2'b11
   } rsf_op_e;
   // Phase states
   typedef enum logic [1:0] {
      RSF_Q1 = 2'b00,
      RSF_Q2 = 2'b01,
      RSF_Q3 = 2'b10,
      RSF_Q4 = 2'b11
   } rsf_phase_e;
endpackage

// ==== rsf_phase.sv ====
// Four-phase sequencer for the rotate/set file-op decoder.
// Assumes synchronous active-high reset on the core clock.
module rsf_phase
   import rsf_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // Phase outputs
   output rsf_phase_e      phase_o,
   output logic            cycle_start_o
);
   rsf_phase_e phase_reg;

   // Free-running four-phase counter
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         phase_reg <= RSF_Q1;
      end else begin
         case (phase_reg)
            RSF_Q1:  phase_reg <= RSF_Q2;
            RSF_Q2:  phase_reg <= RSF_Q3;
            RSF_Q3:  phase_reg <= RSF_Q4;
            RSF_Q4:  phase_reg <= RSF_Q1;
            default: phase_reg <= RSF_Q1;
         endcase
      end
   end

   assign phase_o       = phase_reg;
   assign cycle_start_o = (phase_reg == RSF_Q1);

   // Cycle is four phases long
   AST_PHASE_WRAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      phase_reg == RSF_Q1 |=> phase_reg == RSF_Q2 ##1 phase_reg == RSF_Q3
      ##1 phase_reg == RSF_Q4 ##1 phase_reg == RSF_Q1)
      else $error("phase sequence broken");
endmodule

// ==== rsf_file_ops.sv ====
// Decoder and executor for rotate-right and set-file instructions.
// Assumes a register file answering reads combinationally within phase Q2.
module rsf_file_ops
   import rsf_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // Instruction word, held stable across a cycle
   input  wire logic [15:0] instr_i,
   input  wire logic        instr_valid_i,
   // Core configuration
   input  wire logic [3:0]  bank_select_reg_i,
   input  wire logic        ext_set_en_i,
   input  wire logic [11:0] index_base_i,
   // Register file port
   output logic [11:0]      file_addr_o,
   output logic             file_rd_o,
   input  wire logic [7:0]  file_rdata_i,
   output logic             file_wr_o,
   output logic [7:0]       file_wdata_o,
   // Working register and status
   output logic [7:0]       w_o,
   output logic [7:0]       status_o,
   // Sequencing
   output logic [1:0]       phase_o,
   output logic             busy_o,
   output logic             illegal_o
);
   // Only an 8-bit file address field is served
   if (ADDR_W != 8) begin : g_addr_w_check
      $error("ADDR_W must be 8");
   end

   rsf_phase_e      phase;
   logic            cyc_start;
   rsf_op_e         op_reg;
   logic            dest_reg;
   logic            illegal_reg;
   logic [11:0]     addr_reg;
   logic [7:0]      opnd_reg;
   logic [7:0]      res_reg;
   logic [7:0]      res_next;
   logic            c_next;
   logic [7:0]      w_reg;
   logic [7:0]      status_reg;
   logic            wr_reg;
   logic [7:0]      wdata_reg;

   rsf_phase u_phase (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .phase_o       (phase),
      .cycle_start_o (cyc_start)
   );

   // Decode opcode into an operation kind
   function automatic rsf_op_e decode_op(input logic [15:0] iw);
      rsf_op_e k;
      k = RSF_NONE;
      if (iw[15:10] == RSF_OP_RRC) k = RSF_RRC;
      else if (iw[15:10] == RSF_OP_RRN) k = RSF_RRN;
      else if (iw[15:9] == RSF_OP_SET) k = RSF_SET_FILE_ALL_ONES;
      return k;
   endfunction

   // Effective 12-bit file address from f, a and bank state
   function automatic logic [11:0] eff_addr(input logic [7:0] f,
                                             input logic a,
                                             input logic [3:0] bank_select_reg,
                                             input logic ext,
                                             input logic [11:0] base);
      logic [11:0] ea;
      ea = {bank_select_reg, f};
      if (!a) begin
         if (ext && f <= RSF_IDX_LIMIT) begin
            ea = 12'(base + {4'h0, f});
         end else if (f < RSF_ACC_SPLIT) begin
            ea = {RSF_ACC_LO_BNK, f};
         end else begin
            ea = {RSF_ACC_HI_BNK, f};
         end
      end
      return ea;
   endfunction

   // Q1: latch decode, address and destination
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         op_reg      <= RSF_NONE;
         dest_reg    <= 1'b0;
         addr_reg    <= 12'h000;
         illegal_reg <= 1'b0;
      end else if (phase == RSF_Q1) begin
         op_reg      <= instr_valid_i ? decode_op(instr_i) : RSF_NONE;
         dest_reg    <= instr_i[RSF_D_BIT];
         addr_reg    <= eff_addr(instr_i[7:0], instr_i[RSF_A_BIT],
                                 bank_select_reg_i, ext_set_en_i,
                                 index_base_i);
         illegal_reg <= instr_valid_i && (decode_op(instr_i) == RSF_NONE);
      end
   end

   // Q2: read operand from the file
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         opnd_reg <= 8'h00;
      end else if (phase == RSF_Q2) begin
         opnd_reg <= file_rdata_i;
      end
   end

   // Result and carry from the operand
   always_comb begin
      res_next = opnd_reg;
      c_next   = status_reg[RSF_C_BIT];
      case (op_reg)
         RSF_RRC: begin
            res_next = {status_reg[RSF_C_BIT], opnd_reg[7:1]};
            c_next   = opnd_reg[0];
         end
         RSF_RRN:  res_next = {opnd_reg[0], opnd_reg[7:1]};
         RSF_SET_FILE_ALL_ONES: res_next = RSF_ALL_ONES;
         default:  res_next = opnd_reg;
      endcase
   end

   // Q3: process data
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         res_reg <= 8'h00;
      end else if (phase == RSF_Q3) begin
         res_reg <= res_next;
      end
   end

   // Q4: status flags
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         status_reg <= RSF_STATUS_RST;
      end else if (phase == RSF_Q4) begin
         if (op_reg == RSF_RRC || op_reg == RSF_RRN) begin
            status_reg[RSF_N_BIT] <= res_reg[7];
            status_reg[RSF_Z_BIT] <= (res_reg == 8'h00);
         end
         if (op_reg == RSF_RRC) begin
            status_reg[RSF_C_BIT] <= c_next;
         end
      end
   end

   // Q4: working register destination
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         w_reg <= RSF_W_RST;
      end else if (phase == RSF_Q4 && !dest_reg &&
                   (op_reg == RSF_RRC || op_reg == RSF_RRN)) begin
         w_reg <= res_reg;
      end
   end

   // Q4: file write strobe, one clock long
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_reg    <= 1'b0;
         wdata_reg <= 8'h00;
      end else begin
         wr_reg    <= (phase == RSF_Q3) && ((op_reg == RSF_SET_FILE_ALL_ONES) ||
                      (dest_reg && op_reg != RSF_NONE));
         wdata_reg <= res_next;
      end
   end

   // Outputs; all state is plain flip-flops, safe with a stopped clock
   assign file_addr_o  = addr_reg;
   assign file_rd_o    = (phase == RSF_Q2) && (op_reg != RSF_NONE);
   assign file_wr_o    = wr_reg;
   assign file_wdata_o = wdata_reg;
   assign w_o          = w_reg;
   assign status_o     = status_reg;
   assign phase_o      = phase;
   assign busy_o       = !cyc_start;
   assign illegal_o    = illegal_reg;

   // Named steps of one rotate or set cycle
   sequence s_rot_q4;
      phase == RSF_Q4 && (op_reg == RSF_RRC || op_reg == RSF_RRN);
   endsequence

   sequence s_rot_q1;
      phase == RSF_Q1 && instr_valid_i &&
      (instr_i[15:10] == RSF_OP_RRC || instr_i[15:10] == RSF_OP_RRN);
   endsequence

   sequence s_set_q3;
      phase == RSF_Q3 && op_reg == RSF_SET_FILE_ALL_ONES;
   endsequence

   // Write strobe high for exactly one clock
   sequence s_wr_pulse;
      file_wr_o ##1 !file_wr_o;
   endsequence

   // Carry handling of both rotates
   AST_RRC_CARRY: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q4 && op_reg == RSF_RRC
      |=> status_reg[RSF_C_BIT] == $past(opnd_reg[0]))
      else $error("carry not taken from bit 0");
   AST_RRN_CARRY: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q4 && op_reg == RSF_RRN |=> $stable(status_reg)
      || status_reg[RSF_C_BIT] == $past(status_reg[RSF_C_BIT]))
      else $error("plain rotate changed carry");

   // Negative and zero flags follow the result
   AST_FLAGS_NZ: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      s_rot_q4 |=> status_reg[RSF_N_BIT] == $past(res_reg[7]) &&
      status_reg[RSF_Z_BIT] == ($past(res_reg) == 8'h00))
      else $error("negative or zero flag wrong");

   // Set keeps flags and W, writes all ones for one clock
   AST_SET_NOFLAG: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q4 && op_reg == RSF_SET_FILE_ALL_ONES |=> $stable(status_reg)
      && $stable(w_reg))
      else $error("set changed status or W");
   AST_SET_WRITE: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      s_set_q3
      |=> file_wr_o && file_wdata_o == RSF_ALL_ONES)
      else $error("set did not write ff");
   AST_SET_PULSE: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      s_set_q3 |=> s_wr_pulse)
      else $error("set write pulse not one clock");

   // Destination select of the rotates
   AST_DEST_W: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      (s_rot_q4 and !dest_reg) |-> !file_wr_o
      ##1 w_reg == $past(res_reg))
      else $error("W destination wrong");
   AST_DEST_F: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      (s_rot_q4 and dest_reg) |-> file_wr_o && file_wdata_o == res_reg
      ##1 $stable(w_reg))
      else $error("file destination wrong");

   // Rotate results and operand fetch
   AST_RRC_RES: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q3 && op_reg == RSF_RRC |=> res_reg ==
      {$past(status_reg[RSF_C_BIT]), $past(opnd_reg[7:1])})
      else $error("via-carry result wrong");
   AST_RRN_RES: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q3 && op_reg == RSF_RRN
      |=> res_reg == {$past(opnd_reg[0]), $past(opnd_reg[7:1])})
      else $error("plain rotate result wrong");
   AST_ROT_READ: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      s_rot_q1 |=> file_rd_o ##1 opnd_reg == $past(file_rdata_i))
      else $error("rotate operand not read in Q2");

   // Address forming
   AST_BANK: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q1 && instr_i[RSF_A_BIT]
      |=> addr_reg == {$past(bank_select_reg_i), $past(instr_i[7:0])})
      else $error("bank address wrong");
   AST_ACCESS_LO: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q1 && !instr_i[RSF_A_BIT] && !ext_set_en_i &&
      instr_i[7:0] < RSF_ACC_SPLIT
      |=> addr_reg == {RSF_ACC_LO_BNK, $past(instr_i[7:0])})
      else $error("low access bank address wrong");
   AST_ACCESS_HI: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q1 && !instr_i[RSF_A_BIT] &&
      instr_i[7:0] >= RSF_ACC_SPLIT
      |=> addr_reg == {RSF_ACC_HI_BNK, $past(instr_i[7:0])})
      else $error("high access bank address wrong");
   AST_INDEXED: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q1 && !instr_i[RSF_A_BIT] && ext_set_en_i &&
      instr_i[7:0] <= RSF_IDX_LIMIT
      |=> addr_reg == 12'($past(index_base_i) + $past(instr_i[7:0])))
      else $error("indexed address wrong");

   // Strobes only in their own phase, empty slots stay quiet
   AST_RD_PHASE: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      file_rd_o |-> phase == RSF_Q2)
      else $error("read strobe outside Q2");
   AST_WR_PHASE: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      file_wr_o |-> phase == RSF_Q4)
      else $error("write strobe outside Q4");
   AST_ILLEGAL: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q1 && instr_valid_i && instr_i[15:10] != RSF_OP_RRC &&
      instr_i[15:10] != RSF_OP_RRN && instr_i[15:9] != RSF_OP_SET
      |=> illegal_o && !file_rd_o)
      else $error("unknown word not refused");
   AST_IDLE_QUIET: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      phase == RSF_Q1 && !instr_valid_i |=> !file_rd_o && !illegal_o
      ##2 !file_wr_o ##1 $stable(w_reg) && $stable(status_reg))
      else $error("empty slot touched the file or flags");
endmodule

// ==== rsf_regfile_model.sv ====
// Behavioural register file standing beside the rotate/set file-op block.
// Assumes reads are answered combinationally while the block asserts read.
module rsf_regfile_model (
   // Clock
   input  wire logic        ref_clk_i,
   // Access port from the block
   input  wire logic [11:0] file_addr_i,
   input  wire logic        file_rd_i,
   input  wire logic        file_wr_i,
   input  wire logic [7:0]  file_wdata_i,
   output logic [7:0]       file_rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [4096];
   logic [7:0] last_reg = 8'h5a;
   // Outside a read the data line shows junk, never the last value
   assign file_rdata_o = file_rd_i ? mem[file_addr_i] : ~last_reg;
   // Remember last read; take writes on the clock
   always @(posedge ref_clk_i) begin
      if (file_rd_i) last_reg <= mem[file_addr_i];
      if (file_wr_i) mem[file_addr_i] <= file_wdata_i;
   end
endmodule

// ==== rsf_file_ops_tb_top.sv ====
// Self-checking bench for the rotate/set file-op block.
// Assumes the register file model above and the shared package.
module rsf_file_ops_tb_top;
   import rsf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [15:0] instr_i = 16'h0000;
   logic        instr_valid_i = 1'b0;
   logic [3:0]  bank_select_reg_i = 4'h0;
   logic        ext_set_en_i = 1'b0;
   logic [11:0] index_base_i = 12'h000;
   logic [11:0] file_addr_o;
   logic        file_rd_o, file_wr_o, busy_o, illegal_o;
   logic [7:0]  file_rdata_i, file_wdata_o, w_o, status_o;
   logic [1:0]  phase_o;
   logic [7:0]  w_exp = 8'h00;
   logic [7:0]  st_exp = 8'h00;
   int          num_errors = 0;
   int          checks = 0;
   int          cyc = 0;
   // Device under test
   rsf_file_ops #(.ADDR_W(8)) rsf_file_ops_inst (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_i(instr_i),
      .instr_valid_i(instr_valid_i), .bank_select_reg_i(bank_select_reg_i),
      .ext_set_en_i(ext_set_en_i), .index_base_i(index_base_i),
      .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
      .file_rdata_i(file_rdata_i), .file_wr_o(file_wr_o),
      .file_wdata_o(file_wdata_o), .w_o(w_o), .status_o(status_o),
      .phase_o(phase_o), .busy_o(busy_o), .illegal_o(illegal_o));
   // Register file on the far side
   rsf_regfile_model rsf_regfile_model_inst (
      .ref_clk_i(ref_clk_i), .file_addr_i(file_addr_o),
      .file_rd_i(file_rd_o), .file_wr_i(file_wr_o),
      .file_wdata_i(file_wdata_o), .file_rdata_o(file_rdata_i));
   // Clock, 100 MHz
   initial begin
      forever #(RSF_CLK_NS / 2) ref_clk_i = ~ref_clk_i;
   end
   // Hang guard
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 500) begin
         num_errors++;
         wrap_up();
      end
   end
   // Compare one value
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Issue one instruction word in Q1 and follow it through Q4
   task automatic run(input logic vld, input logic [15:0] ins,
                      input logic [3:0] bank_select_reg, input logic ext,
                      input logic [11:0] base, input logic [7:0] din,
                      input logic [11:0] exp_addr);
      logic [7:0] res;
      logic [7:0] wd;
      logic       wr_exp, wr_seen, ill_seen, rot, known;
      wr_exp = 1'b0; wr_seen = 1'b0; ill_seen = 1'b0; res = 8'h00;
      wd = 8'h00;
      rot = ins[15:10] == RSF_OP_RRC || ins[15:10] == RSF_OP_RRN;
      known = vld && (rot || ins[15:9] == RSF_OP_SET);
      cmp(16'(phase_o), 16'h0000);
      cmp(16'(busy_o), 16'h0000);
      rsf_regfile_model_inst.mem[exp_addr] = din;
      instr_i = ins; instr_valid_i = vld; bank_select_reg_i = bank_select_reg;
      ext_set_en_i = ext; index_base_i = base;
      if (vld && ins[15:10] == RSF_OP_RRC) begin
         res = {st_exp[RSF_C_BIT], din[7:1]};
         st_exp[RSF_C_BIT] = din[0];
      end
      if (vld && ins[15:10] == RSF_OP_RRN) res = {din[0], din[7:1]};
      if (vld && rot) begin
         st_exp[RSF_N_BIT] = res[7];
         st_exp[RSF_Z_BIT] = res == 8'h00;
         if (ins[RSF_D_BIT]) wr_exp = 1'b1;
         else w_exp = res;
      end
      if (known && !rot) begin
         res = RSF_ALL_ONES;
         wr_exp = 1'b1;
      end
      for (int k = 0; k < RSF_PHASES; k++) begin
         @(negedge ref_clk_i);
         if (k == 0) begin
            cmp(16'(file_rd_o), 16'(known));
            if (known) cmp(16'(file_addr_o), 16'(exp_addr));
         end
         if (file_wr_o === 1'b1) begin
            wr_seen = 1'b1;
            wd = file_wdata_o;
         end
         if (illegal_o === 1'b1) ill_seen = 1'b1;
      end
      cmp(16'(wr_seen), 16'(wr_exp));
      if (wr_exp) cmp(16'(wd), 16'(res));
      cmp(16'(w_o), 16'(w_exp));
      cmp(16'(status_o), 16'(st_exp));
      cmp(16'(ill_seen), 16'(vld && !known));
      $display("op %h valid %0d done", ins, vld);
   endtask
   // Print counts and verdict
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Main sequence, instructions back to back
   initial begin
      repeat (6) @(negedge ref_clk_i);
      rst_i = 1'b0;
      run(1, 16'h3225, 4'h0, 0, 12'h000, 8'he7, 12'h025);
      run(1, 16'h3180, 4'h5, 0, 12'h000, 8'h01, 12'h580);
      // Reset in mid-run clears W and status
      rst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      w_exp = RSF_W_RST;
      st_exp = RSF_STATUS_RST;
      cmp(16'(w_o), 16'(w_exp));
      cmp(16'(status_o), 16'(st_exp));
      $display("mid-run reset done");
      run(1, 16'h4070, 4'h5, 1, 12'h123, 8'h00, 12'hf70);
      run(1, 16'h425f, 4'h5, 1, 12'h123, 8'hd7, 12'h182);
      run(1, 16'h6860, 4'h0, 1, 12'h123, 8'h5a, 12'hf60);
      run(1, 16'h69ff, 4'ha, 0, 12'h000, 8'h00, 12'haff);
      run(1, 16'h3200, 4'h0, 0, 12'h000, 8'h00, 12'h000);
      run(1, 16'hffff, 4'h0, 0, 12'h000, 8'h00, 12'h0ff);
      run(0, 16'h3200, 4'h0, 0, 12'h000, 8'h11, 12'h000);
      wrap_up();
   end
endmodule
